/* File: rtl/edge_position_decode.sv */
// Decodes one edge position field into a shift in picoseconds
`timescale 1ns/1ps
`default_nettype none
`include "outif_cfg_defines.svh"

module edge_position_decode #(
	parameter logic [15:0] DIFF_01 = 16'h0000,
	parameter logic [15:0] DIFF_11 = 16'h0000,
	parameter logic [15:0] SE_01   = 16'h0000,
	parameter logic [15:0] SE_10   = 16'h0000,
	parameter logic [15:0] SE_11   = 16'h0000
) (
	input  wire logic        enable_i,
	input  wire logic        differential_i,
	input  wire logic [1:0]  code_i,
	output logic      [15:0] shift_ps_o,
	output logic             align_o
);

	always_comb begin
		shift_ps_o = 16'h0000;
		align_o    = 1'b0;
		// Disabled control or code 00 keeps the default edge
		if (enable_i) begin
			if (differential_i) begin
				unique case (code_i)
					2'h1: shift_ps_o = DIFF_01;
					2'h2: align_o = 1'b1;
					2'h3: shift_ps_o = DIFF_11;
					default: shift_ps_o = 16'h0000;
				endcase
			end else begin
				unique case (code_i)
					2'h1: shift_ps_o = SE_01;
					2'h2: shift_ps_o = SE_10;
					2'h3: shift_ps_o = SE_11;
					default: shift_ps_o = 16'h0000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* File: rtl/outif_cfg.sv */
// Output interface configuration registers on a classic Wishbone slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "outif_cfg_defines.svh"

module outif_cfg (
	input  wire logic                     clock_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [9:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	output logic                          wb_err_o,
	input  wire logic                     format_select_pin_i,
	output logic                          ddr_mode_o,
	output logic                          parallel_mode_o,
	output outif_cfg_pkg::clock_drive_t   single_ended_clock_drive_o,
	output logic      [15:0]              rise_shift_ps_o,
	output logic                          rise_align_o,
	output logic      [15:0]              fall_shift_ps_o,
	output logic                          fall_align_o,
	output logic                          core_powered_o,
	output logic                          output_buffers_powered_o,
	output logic                          reference_powered_o,
	output logic      [7:0]               rise_ctrl_o,
	output logic      [7:0]               fall_ctrl_o
);
	import outif_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser

	logic pin_meta_reg;
	logic pin_sync_reg;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
		end else begin
			pin_meta_reg <= format_select_pin_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one cycle of ack, then one idle cycle

	bus_state_t bus_state_reg;
	bus_state_t bus_state_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic        err_reg;
	logic        err_next;
	logic        request;
	logic        hit_rise;
	logic        hit_fall;
	logic        write_rise;
	logic        write_fall;
	logic [7:0]  rise_value;
	logic [7:0]  fall_value;

	assign request  = wb_cyc_i && wb_stb_i;
	assign hit_rise = wb_adr_i == {`RISE_CTRL_OFFSET, 2'b00};
	assign hit_fall = wb_adr_i == {`FALL_CTRL_OFFSET, 2'b00};

	always_comb begin
		bus_state_next = bus_state_reg;
		dat_next       = dat_reg;
		err_next       = 1'b0;
		write_rise     = 1'b0;
		write_fall     = 1'b0;
		unique case (bus_state_reg)
			BUS_IDLE: begin
				if (request) begin
					bus_state_next = BUS_ACK;
					err_next       = !(hit_rise || hit_fall);
					dat_next       = hit_rise ? {24'h000000, rise_value} :
					                 hit_fall ? {24'h000000, fall_value} : 32'h00000000;
				end
			end
			BUS_ACK: begin
				bus_state_next = BUS_GAP;
				// Store at the edge where the master samples ack; request still stands
				write_rise     = request && wb_we_i && hit_rise && wb_sel_i[0]; // RULE14
				write_fall     = request && wb_we_i && hit_fall && wb_sel_i[0]; // RULE14
			end
			BUS_GAP: begin
				bus_state_next = BUS_IDLE;
			end
			default: begin
				bus_state_next = BUS_IDLE;
			end
		endcase
		// Read of a just-written register shows the new value
		if (write_rise) begin
			dat_next = {24'h000000, wb_dat_i[7:0]};
		end
		if (write_fall) begin
			dat_next = {24'h000000, wb_dat_i[7:0]};
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			bus_state_reg <= BUS_IDLE;
			dat_reg       <= 32'h00000000;
			err_reg       <= 1'b0;
		end else begin
			bus_state_reg <= bus_state_next;
			dat_reg       <= dat_next;
			err_reg       <= err_next;
		end
	end

	assign wb_ack_o = (bus_state_reg == BUS_ACK) && !err_reg;
	assign wb_err_o = (bus_state_reg == BUS_ACK) && err_reg;
	assign wb_dat_o = dat_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	wb_byte_reg #(
		.RESET_VALUE (`RISE_CTRL_RESET)
	) u_rise_reg (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.write_i   (write_rise),
		.data_i    (wb_dat_i[7:0]),
		.value_o   (rise_value)
	);

	// Fixed bits are stored as written; software keeps them at their values
	wb_byte_reg #(
		.RESET_VALUE (`FALL_CTRL_RESET)
	) u_fall_reg (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.write_i   (write_fall),
		.data_i    (wb_dat_i[7:0]),
		.value_o   (fall_value)
	);

	assign rise_ctrl_o = rise_value;
	assign fall_ctrl_o = fall_value;

	////////////////////////////////////////////////////////////////////////////////
	// Interface mode

	logic [1:0] if_sel;
	logic       ddr_next;
	logic       ddr_reg;
	logic       par_reg;
	logic       standby;
	logic       drive_reg;

	assign if_sel  = rise_value[`IF_SEL_MSB:`IF_SEL_LSB];
	assign standby = fall_value[`STANDBY_BIT];

	always_comb begin
		unique case (if_sel)
			IFSEL_DDR: ddr_next = 1'b1;          // RULE2
			IFSEL_PAR: ddr_next = 1'b0;          // RULE2
			default:   ddr_next = !pin_sync_reg; // RULE1
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ddr_reg <= 1'b0;
			par_reg <= 1'b0;
		end else begin
			ddr_reg <= ddr_next;
			par_reg <= !ddr_next;
		end
	end

	assign ddr_mode_o      = ddr_reg;
	assign parallel_mode_o = par_reg;
	// Drive field only reaches the output clock buffer
	assign single_ended_clock_drive_o = clock_drive_t'(rise_value[`CLK_DRIVE_MSB:`CLK_DRIVE_LSB]); // RULE3

	////////////////////////////////////////////////////////////////////////////////
	// Edge placement

	logic [15:0] rise_shift;
	logic [15:0] fall_shift;
	logic        rise_align;
	logic        fall_align;
	logic [15:0] rise_shift_reg;
	logic [15:0] fall_shift_reg;
	logic        rise_align_reg;
	logic        fall_align_reg;

	edge_position_decode #(
		.DIFF_01 (`DIFF_RISE_SHIFT_01_PS),
		.DIFF_11 (`DIFF_RISE_SHIFT_11_PS),
		.SE_01   (`SE_RISE_SHIFT_01_PS),
		.SE_10   (`SE_RISE_SHIFT_10_PS),
		.SE_11   (`SE_RISE_SHIFT_11_PS)
	) u_rise_decode (
		.enable_i       (rise_value[`RISE_EN_BIT]), // RULE5
		.differential_i (ddr_next), // RULE6 RULE7
		.code_i         (rise_value[`RISE_POS_MSB:`RISE_POS_LSB]),
		.shift_ps_o     (rise_shift),
		.align_o        (rise_align)
	);

	edge_position_decode #(
		.DIFF_01 (`DIFF_FALL_SHIFT_01_PS),
		.DIFF_11 (`DIFF_FALL_SHIFT_11_PS),
		.SE_01   (`SE_FALL_SHIFT_01_PS),
		.SE_10   (`SE_FALL_SHIFT_10_PS),
		.SE_11   (`SE_FALL_SHIFT_11_PS)
	) u_fall_decode (
		.enable_i       (rise_value[`FALL_EN_BIT]), // RULE8
		.differential_i (ddr_next), // RULE9 RULE10
		.code_i         (fall_value[`FALL_POS_MSB:`FALL_POS_LSB]),
		.shift_ps_o     (fall_shift),
		.align_o        (fall_align)
	);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rise_shift_reg <= 16'h0000;
			fall_shift_reg <= 16'h0000;
			rise_align_reg <= 1'b0;
			fall_align_reg <= 1'b0;
			drive_reg      <= 1'b1;
		end else begin
			rise_shift_reg <= rise_shift; // RULE11
			fall_shift_reg <= fall_shift; // RULE11
			rise_align_reg <= rise_align;
			fall_align_reg <= fall_align;
			drive_reg      <= !standby; // RULE12
		end
	end

	assign rise_shift_ps_o          = rise_shift_reg;
	assign fall_shift_ps_o          = fall_shift_reg;
	assign rise_align_o             = rise_align_reg;
	assign fall_align_o             = fall_align_reg;
	// Reference stays up in standby so wake-up is quick
	assign core_powered_o           = drive_reg; // RULE12
	assign output_buffers_powered_o = drive_reg; // RULE12
	assign reference_powered_o      = 1'b1;      // RULE12

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_ddr_select;
		@(posedge clock_i) disable iff (sys_rst_i)
		(if_sel == 2'h1) |=> ddr_mode_o && !parallel_mode_o;
	endproperty
	a_ddr_select: assert property (p_ddr_select) else $error("ddr code not honoured"); // RULE2

	property p_pin_select;
		@(posedge clock_i) disable iff (sys_rst_i)
		// Release edge excluded: mode flops are still held in reset there
		(!sys_rst_i && !if_sel[0] && $stable(pin_sync_reg)) |=> (ddr_mode_o == !$past(pin_sync_reg));
	endproperty
	a_pin_select: assert property (p_pin_select) else $error("pin select not honoured"); // RULE1

	property p_drive;
		@(posedge clock_i) disable iff (sys_rst_i)
		single_ended_clock_drive_o == rise_ctrl_o[5:4];
	endproperty
	a_drive: assert property (p_drive) else $error("clock drive mismatch"); // RULE3

	property p_rise_off;
		@(posedge clock_i) disable iff (sys_rst_i)
		!rise_ctrl_o[3] |=> rise_shift_ps_o == 16'h0000 && !rise_align_o;
	endproperty
	a_rise_off: assert property (p_rise_off) else $error("rise shift while disabled"); // RULE5

	property p_fall_off;
		@(posedge clock_i) disable iff (sys_rst_i)
		!rise_ctrl_o[0] |=> fall_shift_ps_o == 16'h0000 && !fall_align_o;
	endproperty
	a_fall_off: assert property (p_fall_off) else $error("fall shift while disabled"); // RULE8

	property p_diff_rise;
		@(posedge clock_i) disable iff (sys_rst_i)
		(ddr_next && rise_ctrl_o[3:1] == 3'h5) |=> rise_shift_ps_o == 16'd500;
	endproperty
	a_diff_rise: assert property (p_diff_rise) else $error("differential rise shift wrong"); // RULE6

	property p_se_rise;
		@(posedge clock_i) disable iff (sys_rst_i)
		(!ddr_next && rise_ctrl_o[3:1] == 3'h7) |=> rise_shift_ps_o == 16'd1500;
	endproperty
	a_se_rise: assert property (p_se_rise) else $error("single-ended rise shift wrong"); // RULE7

	property p_diff_fall;
		@(posedge clock_i) disable iff (sys_rst_i)
		(ddr_next && rise_ctrl_o[0] && fall_ctrl_o[7:6] == 2'h1) |=> fall_shift_ps_o == 16'd400;
	endproperty
	a_diff_fall: assert property (p_diff_fall) else $error("differential fall shift wrong"); // RULE9

	property p_se_fall;
		@(posedge clock_i) disable iff (sys_rst_i)
		(!ddr_next && rise_ctrl_o[0] && fall_ctrl_o[7:6] == 2'h2) |=> fall_shift_ps_o == 16'd200;
	endproperty
	a_se_fall: assert property (p_se_fall) else $error("single-ended fall shift wrong"); // RULE10

	property p_default_pos;
		@(posedge clock_i) disable iff (sys_rst_i)
		(rise_ctrl_o[2:1] == 2'h0) |=> rise_shift_ps_o == 16'h0000 && !rise_align_o;
	endproperty
	a_default_pos: assert property (p_default_pos) else $error("code 00 moved the edge"); // RULE11

	property p_standby;
		@(posedge clock_i) disable iff (sys_rst_i)
		fall_ctrl_o[2] |=> !core_powered_o && !output_buffers_powered_o && reference_powered_o;
	endproperty
	a_standby: assert property (p_standby) else $error("standby power state wrong"); // RULE12

	property p_write_effect;
		@(posedge clock_i) disable iff (sys_rst_i)
		write_fall |=> fall_ctrl_o == $past(wb_dat_i[7:0]);
	endproperty
	a_write_effect: assert property (p_write_effect) else $error("write not applied"); // RULE14

endmodule
`default_nettype wire

/* File: rtl/outif_cfg_defines.svh */
// Offsets, field positions, reset values and edge shift figures of the output interface configuration
// Function
// [RULE1] Select codes 00/10 defer to format pin
// [RULE2] Code 01 gives DDR, 11 gives parallel
// [RULE3] Clock drive field sets clock strength only
// [RULE4] Software should keep clock drive at maximum
// [RULE5] Rise position applies only when enabled
// [RULE6] Differential rise codes: default, 500ps, align, 200ps
// [RULE7] Single-ended rise codes: 100ps, 200ps, 1.5ns
// [RULE8] Fall position applies only when enabled
// [RULE9] Differential fall codes: 400ps, align, 200ps
// [RULE10] Single-ended fall advances 100ps, 200ps, further
// [RULE11] Position code 00 keeps default edge place
// [RULE12] Standby powers core and buffers, keeps reference; the code powers core and buffers down in standby and keeps the reference up
// [RULE13] Software writes fixed bits of fall register
// [RULE14] New values act right after the write
`ifndef OUTIF_CFG_DEFINES_SVH
`define OUTIF_CFG_DEFINES_SVH

`define RISE_CTRL_OFFSET      8'h41
`define FALL_CTRL_OFFSET      8'h42
`define RISE_CTRL_RESET       8'h00
`define FALL_CTRL_RESET       8'h08
`define FALL_CTRL_FIXED_MASK  8'h3b
`define FALL_CTRL_FIXED_VALUE 8'h08

`define IF_SEL_MSB            7
`define IF_SEL_LSB            6
`define CLK_DRIVE_MSB         5
`define CLK_DRIVE_LSB         4
`define RISE_EN_BIT           3
`define RISE_POS_MSB          2
`define RISE_POS_LSB          1
`define FALL_EN_BIT           0
`define FALL_POS_MSB          7
`define FALL_POS_LSB          6
`define STANDBY_BIT           2

// Edge shifts in picoseconds: setup loss / hold gain, or fall advance
`define DIFF_RISE_SHIFT_01_PS 16'd500
`define DIFF_RISE_SHIFT_11_PS 16'd200
`define SE_RISE_SHIFT_01_PS   16'd100
`define SE_RISE_SHIFT_10_PS   16'd200
`define SE_RISE_SHIFT_11_PS   16'd1500
`define DIFF_FALL_SHIFT_01_PS 16'd400
`define DIFF_FALL_SHIFT_11_PS 16'd200
`define SE_FALL_SHIFT_01_PS   16'd100
`define SE_FALL_SHIFT_10_PS   16'd200
`define SE_FALL_SHIFT_11_PS   16'd300

`endif

/* File: rtl/outif_cfg_pkg.sv */
// Types for the output interface configuration block
package outif_cfg_pkg;

	typedef enum logic [1:0] {
		IFSEL_PIN_A = 2'h0,
		IFSEL_DDR   = 2'h1,
		IFSEL_PIN_B = 2'h2,
		IFSEL_PAR   = 2'h3
	} if_select_t;

	typedef enum logic [1:0] {
		DRIVE_MAX      = 2'h0,
		DRIVE_MEDIUM   = 2'h1,
		DRIVE_LOW      = 2'h2,
		DRIVE_VERY_LOW = 2'h3
	} clock_drive_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'h1,
		BUS_ACK  = 3'h2,
		BUS_GAP  = 3'h4
	} bus_state_t;

endpackage

/* File: rtl/wb_byte_reg.sv */
// One byte-wide configuration register with reset value and write enable
`timescale 1ns/1ps
`default_nettype none

module wb_byte_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	input  wire logic       write_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] value_o
);

	logic [7:0] value_reg;
	logic [7:0] value_next;

	always_comb begin
		value_next = write_i ? data_i : value_reg;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			value_reg <= RESET_VALUE;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value_o = value_reg;

endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the output interface configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "outif_cfg_defines.svh"

`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: %s", $time, msg); end end

module tb;
	import outif_cfg_pkg::*;

	typedef struct packed {
		logic [7:0]  r41;
		logic [7:0]  r42;
		logic        pin;
		logic        ddr;
		logic        par;
		logic [1:0]  drv;
		logic [15:0] rs;
		logic        ra;
		logic [15:0] fs;
		logic        fa;
		logic        pwr;
	} row_t;

	logic          clock_i;
	logic          sys_rst_i;
	logic          wb_cyc_i;
	logic          wb_stb_i;
	logic          wb_we_i;
	logic [9:0]    wb_adr_i;
	logic [3:0]    wb_sel_i;
	logic [31:0]   wb_dat_i;
	logic [31:0]   wb_dat_o;
	logic          wb_ack_o;
	logic          wb_err_o;
	logic          format_select_pin_i;
	logic          ddr_mode_o;
	logic          parallel_mode_o;
	clock_drive_t  single_ended_clock_drive_o;
	logic [15:0]   rise_shift_ps_o;
	logic          rise_align_o;
	logic [15:0]   fall_shift_ps_o;
	logic          fall_align_o;
	logic          core_powered_o;
	logic          output_buffers_powered_o;
	logic          reference_powered_o;
	logic [7:0]    rise_ctrl_o;
	logic [7:0]    fall_ctrl_o;
	int            miscompares;
	int            checks_done;
	row_t          rows [14];
	logic [7:0]    rd;
	logic          er;

	outif_cfg dut (
		.clock_i                    (clock_i),
		.sys_rst_i                  (sys_rst_i),
		.wb_cyc_i                   (wb_cyc_i),
		.wb_stb_i                   (wb_stb_i),
		.wb_we_i                    (wb_we_i),
		.wb_adr_i                   (wb_adr_i),
		.wb_sel_i                   (wb_sel_i),
		.wb_dat_i                   (wb_dat_i),
		.wb_dat_o                   (wb_dat_o),
		.wb_ack_o                   (wb_ack_o),
		.wb_err_o                   (wb_err_o),
		.format_select_pin_i        (format_select_pin_i),
		.ddr_mode_o                 (ddr_mode_o),
		.parallel_mode_o            (parallel_mode_o),
		.single_ended_clock_drive_o (single_ended_clock_drive_o),
		.rise_shift_ps_o            (rise_shift_ps_o),
		.rise_align_o               (rise_align_o),
		.fall_shift_ps_o            (fall_shift_ps_o),
		.fall_align_o               (fall_align_o),
		.core_powered_o             (core_powered_o),
		.output_buffers_powered_o   (output_buffers_powered_o),
		.reference_powered_o        (reference_powered_o),
		.rise_ctrl_o                (rise_ctrl_o),
		.fall_ctrl_o                (fall_ctrl_o)
	);

	initial clock_i = 1'h0;
	always #5 clock_i = ~clock_i;

	task automatic end_sim;
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Classic single cycle; the master waits for ack or err, the watchdog bounds it
	task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [7:0] d,
		input logic [3:0] sel, output logic [7:0] q, output logic e);
		@(posedge clock_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge clock_i);
		end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
		q = wb_dat_o[7:0];
		e = wb_err_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i  <= 1'h0;
	endtask

	// Hang guard: the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clock_i);
		miscompares++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		miscompares = 0;
		checks_done = 0;
		sys_rst_i = 1'h1;
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i = 1'h0;
		wb_adr_i = 10'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		format_select_pin_i = 1'h0;
		// r41 r42 pin ddr par drv rise_ps ralign fall_ps falign powered
		rows = '{
			'{8'h40, 8'h08, 1'h0, 1'h1, 1'h0, 2'h0, 16'h0000, 1'h0, 16'h0000, 1'h0, 1'h1},
			'{8'h4b, 8'h48, 1'h0, 1'h1, 1'h0, 2'h0, `DIFF_RISE_SHIFT_01_PS, 1'h0, `DIFF_FALL_SHIFT_01_PS, 1'h0, 1'h1},
			'{8'h5d, 8'h88, 1'h1, 1'h1, 1'h0, 2'h1, 16'h0000, 1'h1, 16'h0000, 1'h1, 1'h1},
			'{8'h6f, 8'hc8, 1'h0, 1'h1, 1'h0, 2'h2, `DIFF_RISE_SHIFT_11_PS, 1'h0, `DIFF_FALL_SHIFT_11_PS, 1'h0, 1'h1},
			'{8'hfb, 8'h48, 1'h0, 1'h0, 1'h1, 2'h3, `SE_RISE_SHIFT_01_PS, 1'h0, `SE_FALL_SHIFT_01_PS, 1'h0, 1'h1},
			'{8'hcd, 8'h88, 1'h0, 1'h0, 1'h1, 2'h0, `SE_RISE_SHIFT_10_PS, 1'h0, `SE_FALL_SHIFT_10_PS, 1'h0, 1'h1},
			'{8'hcf, 8'hc8, 1'h0, 1'h0, 1'h1, 2'h0, `SE_RISE_SHIFT_11_PS, 1'h0, `SE_FALL_SHIFT_11_PS, 1'h0, 1'h1},
			'{8'hc6, 8'hc8, 1'h0, 1'h0, 1'h1, 2'h0, 16'h0000, 1'h0, 16'h0000, 1'h0, 1'h1},
			'{8'hc9, 8'h08, 1'h0, 1'h0, 1'h1, 2'h0, 16'h0000, 1'h0, 16'h0000, 1'h0, 1'h1},
			'{8'h0b, 8'h48, 1'h0, 1'h1, 1'h0, 2'h0, `DIFF_RISE_SHIFT_01_PS, 1'h0, `DIFF_FALL_SHIFT_01_PS, 1'h0, 1'h1},
			'{8'h0b, 8'h48, 1'h1, 1'h0, 1'h1, 2'h0, `SE_RISE_SHIFT_01_PS, 1'h0, `SE_FALL_SHIFT_01_PS, 1'h0, 1'h1},
			'{8'h8f, 8'hc8, 1'h1, 1'h0, 1'h1, 2'h0, `SE_RISE_SHIFT_11_PS, 1'h0, `SE_FALL_SHIFT_11_PS, 1'h0, 1'h1},
			'{8'h8f, 8'hc8, 1'h0, 1'h1, 1'h0, 2'h0, `DIFF_RISE_SHIFT_11_PS, 1'h0, `DIFF_FALL_SHIFT_11_PS, 1'h0, 1'h1},
			'{8'h40, 8'h0c, 1'h0, 1'h1, 1'h0, 2'h0, 16'h0000, 1'h0, 16'h0000, 1'h0, 1'h0}
		};
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'h0;

		foreach (rows[i]) begin
			format_select_pin_i <= rows[i].pin;
			wb_xfer(1'h1, 10'h104, rows[i].r41, 4'h1, rd, er);
			wb_xfer(1'h1, 10'h108, rows[i].r42, 4'h1, rd, er);
			repeat (4) @(posedge clock_i);
			#1;
			`CHK(ddr_mode_o, rows[i].ddr, "ddr mode")
			`CHK(parallel_mode_o, rows[i].par, "parallel mode")
			`CHK(single_ended_clock_drive_o, rows[i].drv, "clock drive")
			`CHK(rise_shift_ps_o, rows[i].rs, "rise shift")
			`CHK(rise_align_o, rows[i].ra, "rise align")
			`CHK(fall_shift_ps_o, rows[i].fs, "fall shift")
			`CHK(fall_align_o, rows[i].fa, "fall align")
			`CHK(core_powered_o, rows[i].pwr, "core power")
			`CHK(output_buffers_powered_o, rows[i].pwr, "buffer power")
			`CHK(reference_powered_o, 1'h1, "reference power")
			wb_xfer(1'h0, 10'h104, 8'h00, 4'h1, rd, er);
			`CHK(rd, rows[i].r41, "readback 41")
			wb_xfer(1'h0, 10'h108, 8'h00, 4'h1, rd, er);
			`CHK(rd, rows[i].r42, "readback 42")
		end

		`CHK(single_ended_clock_drive_o, DRIVE_MAX, "drive left at max")
		// Unmapped address: error answer, nothing stored
		wb_xfer(1'h1, 10'h10c, 8'hff, 4'h1, rd, er);
		`CHK(er, 1'h1, "unmapped err")
		`CHK(rise_ctrl_o, 8'h40, "unmapped write leak")
		// Byte lane off: acked, not stored
		wb_xfer(1'h1, 10'h104, 8'hcf, 4'h0, rd, er);
		`CHK(er, 1'h0, "sel off err")
		`CHK(rise_ctrl_o, 8'h40, "sel off write leak")
		// Mode must follow the write one edge after ack, no extra command
		wb_xfer(1'h1, 10'h104, 8'hc0, 4'h1, rd, er);
		@(posedge clock_i);
		#1;
		`CHK(parallel_mode_o, 1'h1, "late mode update")
		wb_xfer(1'h1, 10'h108, 8'h08, 4'h1, rd, er);
		@(posedge clock_i);
		#1;
		`CHK(core_powered_o, 1'h1, "late wake")

		// Reset in mid-run restores defaults
		@(posedge clock_i);
		sys_rst_i <= 1'h1;
		repeat (3) @(posedge clock_i);
		#1;
		`CHK(rise_ctrl_o, 8'h00, "rise reg reset")
		`CHK(fall_ctrl_o, 8'h08, "fall reg reset")
		`CHK(ddr_mode_o | parallel_mode_o, 1'h0, "mode in reset")
		`CHK(core_powered_o, 1'h1, "power in reset")
		@(posedge clock_i);
		sys_rst_i <= 1'h0;
		repeat (4) @(posedge clock_i);
		#1;
		`CHK(ddr_mode_o, 1'h1, "pin low defers to ddr")
		`CHK(rise_shift_ps_o, 16'h0000, "default rise")
		wb_xfer(1'h0, 10'h108, 8'h00, 4'h1, rd, er);
		`CHK(rd, 8'h08, "fall reg readback")
		end_sim();
	end
endmodule

`default_nettype wire
